// File: gdi_defines.svh
// register offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from any file of the door interlock
`ifndef GDI_DEFINES_SVH
`define GDI_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define GDI_OFS_CTRL 5'h00
`define GDI_OFS_DELAY 5'h04
`define GDI_OFS_STATUS 5'h08
`define GDI_OFS_IRQ_STAT 5'h0c
`define GDI_OFS_IRQ_MASK 5'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define GDI_CTRL_START_EN 0
`define GDI_CTRL_RST 1'h1
`define GDI_ST_LOCK_ERR 8
`define GDI_ST_ACT_ERR 9
`define GDI_ST_HW_ERR 10
`define GDI_ST_PASSIV 11
`define GDI_ST_DOOR 12
`define GDI_ST_LOCK_FB 13
`define GDI_ST_ACK_REQ 14
`define GDI_IRQ_FAULT 0
`define GDI_IRQ_ACK_REQ 1
`define GDI_IRQ_RELEASE 2
`define GDI_IRQ_RUN 3
`define GDI_IRQ_W 4
`define GDI_IRQ_MASK_RST 4'h0

// ----------------------------------------
// pin indices of the synchroniser
// ----------------------------------------
`define GDI_PIN_START 0
`define GDI_PIN_STOP 1
`define GDI_PIN_ACK 2
`define GDI_PIN_RESET 3
`define GDI_PIN_DOOR 4
`define GDI_PIN_LOCK_FB 5
`define GDI_PIN_CONT_FB 6
`define GDI_PIN_EXT_V 7
`define GDI_PIN_MOD_MISS 8
`define GDI_NPINS 9

// ----------------------------------------
// timing
// ----------------------------------------
`define GDI_CLK_HZ 10000000
`define GDI_TICK_MS 1
`define GDI_CYC_PER_MS (`GDI_CLK_HZ / 1000 * `GDI_TICK_MS)
`define GDI_UNLOCK_MS 5000
`define GDI_LOCK_TMO_MS 100
`define GDI_FB_MS 50

`endif

// File: gdi_pkg.sv
// types shared by the door interlock files
// assumes nothing beyond a SystemVerilog compiler
package gdi_pkg;

	// ----------------------------------------
	// sequencer states, one-hot
	// ----------------------------------------
	typedef enum logic [7:0] {
		ST_INIT = 8'h01,
		ST_OPEN = 8'h02,
		ST_ACKW = 8'h04,
		ST_READY = 8'h08,
		ST_LOCKING = 8'h10,
		ST_RUN = 8'h20,
		ST_UNLOCK_DLY = 8'h40,
		ST_FAULT = 8'h80
	} gdi_state_e;

	typedef logic [15:0] gdi_ms_t;

endpackage

// File: gdi_pin_if.sv
// carries synchronised pin levels from the synchroniser to the sequencer
// assumes one clock domain on the consuming side
`timescale 1ns/1ps

interface gdi_pin_if #(
	parameter int N = 9
);
	logic [N-1:0] level;

	modport src (output level);
	modport dst (input level);
endinterface

// File: gdi_pin_sync.sv
// three-stage synchroniser for asynchronous pins
// assumes pins from outside the clock domain; reset asynchronous low
`timescale 1ns/1ps

module gdi_pin_sync #(
	parameter int N = 9
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [N-1:0] pins_i,
	gdi_pin_if.src sync
);

	logic [N-1:0] ff1_r;
	logic [N-1:0] ff2_r;
	logic [N-1:0] ff3_r;
	logic [N-1:0] level_r;

	// ----------------------------------------
	// shift chain; first stage feeds only the second
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ff1_r <= '0;
			ff2_r <= '0;
			ff3_r <= '0;
		end else begin
			ff1_r <= pins_i;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
		end
	end

	// a change counts once stages two and three agree, hiding one-cycle glitches
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_r <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (ff2_r[i] == ff3_r[i]) begin
					level_r[i] <= ff3_r[i];
				end
			end
		end
	end

	assign sync.level = level_r;

endmodule

// File: gdi_door_lock_supervisor.sv
// sequencer for a guarded machine with a locking protective door
// assumes buttons and sensors arrive raw on pins; one 10 MHz clock
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "gdi_defines.svh"

module gdi_door_lock_supervisor #(
	parameter int CYC_PER_MS = `GDI_CYC_PER_MS,
	parameter int UNLOCK_MS = `GDI_UNLOCK_MS,
	parameter int LOCK_TMO_MS = `GDI_LOCK_TMO_MS,
	parameter int FB_MS = `GDI_FB_MS
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic start_btn_i,
	input wire logic stop_btn_i,
	input wire logic ack_btn_i,
	input wire logic reset_btn_i,
	input wire logic door_closed_i,
	input wire logic lock_fb_i,
	input wire logic contactor_fb_i,
	input wire logic ext_volt_i,
	input wire logic module_missing_i,
	input wire logic [4:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic machine_en_o,
	output logic lock_solenoid_o,
	output logic ack_req_o,
	output logic led_red_o,
	output logic led_green_o,
	output logic irq_o
);

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	gdi_pin_if #(.N(`GDI_NPINS)) pins ();

	gdi_pin_sync #(.N(`GDI_NPINS)) u_sync (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.pins_i({module_missing_i, ext_volt_i, contactor_fb_i, lock_fb_i, door_closed_i,
			reset_btn_i, ack_btn_i, stop_btn_i, start_btn_i}),
		.sync(pins)
	);

	logic [`GDI_NPINS-1:0] lvl_d_r;
	logic start_p, stop_p, ack_p, rst_p;
	logic door, lock_fb, cont_fb, hw_cause;

	// buttons act on the press edge, so a held button fires once
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lvl_d_r <= '0;
		end else begin
			lvl_d_r <= pins.level;
		end
	end

	assign start_p = pins.level[`GDI_PIN_START] & ~lvl_d_r[`GDI_PIN_START];
	assign stop_p = pins.level[`GDI_PIN_STOP] & ~lvl_d_r[`GDI_PIN_STOP];
	assign ack_p = pins.level[`GDI_PIN_ACK] & ~lvl_d_r[`GDI_PIN_ACK];
	assign rst_p = pins.level[`GDI_PIN_RESET] & ~lvl_d_r[`GDI_PIN_RESET];
	assign door = pins.level[`GDI_PIN_DOOR];
	assign lock_fb = pins.level[`GDI_PIN_LOCK_FB];
	assign cont_fb = pins.level[`GDI_PIN_CONT_FB];
	assign hw_cause = pins.level[`GDI_PIN_EXT_V] | pins.level[`GDI_PIN_MOD_MISS];

	// ----------------------------------------
	// millisecond tick divider
	// ----------------------------------------
	logic [23:0] div_r;
	logic ms_tick_r;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_r <= '0;
			ms_tick_r <= 1'b0;
		end else if (div_r == 24'(CYC_PER_MS - 1)) begin
			div_r <= '0;
			ms_tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 24'h000001;
			ms_tick_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// registers written by software
	// ----------------------------------------
	logic start_en_r;
	gdi_pkg::gdi_ms_t delay_r;
	logic [`GDI_IRQ_W-1:0] irq_mask_r;
	logic [`GDI_IRQ_W-1:0] irq_stat_r;
	logic [`GDI_IRQ_W-1:0] irq_stat_nxt;
	logic [`GDI_IRQ_W-1:0] ev;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_en_r <= `GDI_CTRL_RST;
			delay_r <= gdi_pkg::gdi_ms_t'(UNLOCK_MS);
			irq_mask_r <= `GDI_IRQ_MASK_RST;
		end else if (wr_i) begin
			case (addr_i)
				`GDI_OFS_CTRL: start_en_r <= wdata_i[`GDI_CTRL_START_EN];
				`GDI_OFS_DELAY: delay_r <= wdata_i[15:0];
				`GDI_OFS_IRQ_MASK: irq_mask_r <= wdata_i[`GDI_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// error latches
	// ----------------------------------------
	logic lock_err_r, act_err_r, hw_err_r, passiv_r;
	logic lock_err_set, act_err_set, err_any, tmr_zero;
	gdi_pkg::gdi_ms_t fb_cnt_r, tmr_r;
	gdi_pkg::gdi_state_e state_r, state_nxt;

	assign tmr_zero = (tmr_r == '0);
	assign err_any = lock_err_r | act_err_r | hw_err_r;

	// lock missing while it should hold, or never confirmed while engaging
	assign lock_err_set = ((state_r == gdi_pkg::ST_RUN || state_r == gdi_pkg::ST_UNLOCK_DLY)
		&& (!lock_fb || !door)) || (state_r == gdi_pkg::ST_LOCKING && tmr_zero);
	// contactor disagreeing with the enable covers a welded contact too
	assign act_err_set = (fb_cnt_r == gdi_pkg::gdi_ms_t'(FB_MS));

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fb_cnt_r <= '0;
		end else if (cont_fb == machine_en_o) begin
			fb_cnt_r <= '0;
		end else if (ms_tick_r && !act_err_set) begin
			fb_cnt_r <= fb_cnt_r + 16'h0001;
		end
	end

	// set wins over the clear of a reset press, so a standing cause stays latched
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lock_err_r <= 1'b0;
			act_err_r <= 1'b0;
			hw_err_r <= 1'b0;
			passiv_r <= 1'b0;
		end else begin
			lock_err_r <= lock_err_set | (lock_err_r & ~rst_p);
			act_err_r <= act_err_set | (act_err_r & ~rst_p);
			hw_err_r <= hw_cause | (hw_err_r & ~rst_p);
			passiv_r <= hw_cause | (passiv_r & ~rst_p);
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			gdi_pkg::ST_INIT: begin
				// door seen on ms ticks only, once the synchroniser has left reset (CYC_PER_MS >= 4)
				if (!door && ms_tick_r) begin
					state_nxt = gdi_pkg::ST_OPEN;
				end
			end
			gdi_pkg::ST_OPEN: begin
				if (door) begin
					state_nxt = gdi_pkg::ST_ACKW;
				end
			end
			gdi_pkg::ST_ACKW: begin
				if (!door) begin
					state_nxt = gdi_pkg::ST_OPEN;
				end else if (ack_p) begin
					state_nxt = gdi_pkg::ST_READY;
				end
			end
			gdi_pkg::ST_READY: begin
				if (!door) begin
					state_nxt = gdi_pkg::ST_OPEN;
				end else if (start_p && start_en_r) begin
					state_nxt = gdi_pkg::ST_LOCKING;
				end
			end
			gdi_pkg::ST_LOCKING: begin
				if (stop_p || !door) begin
					state_nxt = gdi_pkg::ST_READY;
				end else if (lock_fb) begin
					state_nxt = gdi_pkg::ST_RUN;
				end
			end
			gdi_pkg::ST_RUN: begin
				if (stop_p) begin
					state_nxt = gdi_pkg::ST_UNLOCK_DLY;
				end
			end
			gdi_pkg::ST_UNLOCK_DLY: begin
				if (start_p && start_en_r && door && lock_fb) begin
					state_nxt = gdi_pkg::ST_RUN;
				end else if (tmr_zero) begin
					state_nxt = gdi_pkg::ST_READY;
				end
			end
			gdi_pkg::ST_FAULT: begin
				// leave only once reset clears errors whose cause is gone
				if (rst_p && !hw_cause && !lock_err_set && !act_err_set) begin
					state_nxt = door ? gdi_pkg::ST_READY : gdi_pkg::ST_OPEN;
				end
			end
			default: state_nxt = gdi_pkg::ST_INIT;
		endcase
		if (err_any && state_r != gdi_pkg::ST_FAULT) begin
			state_nxt = gdi_pkg::ST_FAULT;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= gdi_pkg::ST_INIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// one timer serves the unlock delay, the fault delay and the lock timeout
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tmr_r <= '0;
		end else if (state_nxt != state_r) begin
			if (state_nxt == gdi_pkg::ST_LOCKING) begin
				tmr_r <= gdi_pkg::gdi_ms_t'(LOCK_TMO_MS);
			end else begin
				tmr_r <= delay_r;
			end
		end else if (ms_tick_r && !tmr_zero) begin
			tmr_r <= tmr_r - 16'h0001;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// solenoid powered means unlocked; after a fault the door stays held until the delay ends or a reset press leaves the fault state
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			machine_en_o <= 1'b0;
			lock_solenoid_o <= 1'b1;
			ack_req_o <= 1'b0;
			led_red_o <= 1'b0;
			led_green_o <= 1'b1;
		end else begin
			machine_en_o <= (state_nxt == gdi_pkg::ST_RUN) && !err_any;
			lock_solenoid_o <= (state_nxt == gdi_pkg::ST_INIT) || (state_nxt == gdi_pkg::ST_OPEN)
				|| (state_nxt == gdi_pkg::ST_ACKW) || (state_nxt == gdi_pkg::ST_READY)
				|| (state_nxt == gdi_pkg::ST_FAULT && state_r == gdi_pkg::ST_FAULT
				&& tmr_zero);
			ack_req_o <= (state_nxt == gdi_pkg::ST_ACKW);
			led_red_o <= hw_err_r;
			led_green_o <= ~hw_err_r;
		end
	end

	// ----------------------------------------
	// interrupt status, write one to clear
	// ----------------------------------------
	assign ev[`GDI_IRQ_FAULT] = (state_nxt == gdi_pkg::ST_FAULT) && (state_r != gdi_pkg::ST_FAULT);
	assign ev[`GDI_IRQ_ACK_REQ] = (state_nxt == gdi_pkg::ST_ACKW) && (state_r != gdi_pkg::ST_ACKW);
	assign ev[`GDI_IRQ_RELEASE] = (state_r == gdi_pkg::ST_UNLOCK_DLY)
		&& (state_nxt == gdi_pkg::ST_READY);
	assign ev[`GDI_IRQ_RUN] = (state_nxt == gdi_pkg::ST_RUN) && (state_r != gdi_pkg::ST_RUN);

	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (wr_i && addr_i == `GDI_OFS_IRQ_STAT) begin
			irq_stat_nxt = irq_stat_r & ~wdata_i[`GDI_IRQ_W-1:0];
		end
		irq_stat_nxt = irq_stat_nxt | ev;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_stat_r <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			irq_o <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// ----------------------------------------
	// read port, data valid the cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			case (addr_i)
				`GDI_OFS_CTRL: rdata_o <= {31'h0, start_en_r};
				`GDI_OFS_DELAY: rdata_o <= {16'h0, delay_r};
				`GDI_OFS_STATUS: rdata_o <= {17'h0, ack_req_o, lock_fb, door, passiv_r,
					hw_err_r, act_err_r, lock_err_r, state_r};
				`GDI_OFS_IRQ_STAT: rdata_o <= {28'h0, irq_stat_r};
				`GDI_OFS_IRQ_MASK: rdata_o <= {28'h0, irq_mask_r};
				default: rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

endmodule

// File: gdi_plant_model.sv
// far-side model: door bolt switch and motor contactor feedback
// assumes the supervisor's clock and reset; weld_i forces a stuck contactor
`timescale 1ns/1ps

module gdi_plant_model (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic machine_en_i,
	input wire logic lock_solenoid_i,
	input wire logic door_closed_i,
	input wire logic weld_i,
	output logic lock_fb_o,
	output logic contactor_fb_o
);
	// ----------------------------------------
	// feedback
	// ----------------------------------------
	// bolt engages only on a closed door with the solenoid off
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lock_fb_o <= 1'b0;
			contactor_fb_o <= 1'b0;
		end else begin
			lock_fb_o <= door_closed_i & ~lock_solenoid_i;
			contactor_fb_o <= machine_en_i | weld_i;
		end
	end
endmodule

// File: gdi_checker_properties.sv
// concurrent checks on the interlock top-level ports
// assumes a bind onto gdi_door_lock_supervisor; one clock domain
`timescale 1ns/1ps

module gdi_checker (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic stop_btn_i,
	input wire logic door_closed_i,
	input wire logic ext_volt_i,
	input wire logic machine_en_o,
	input wire logic lock_solenoid_o,
	input wire logic ack_req_o,
	input wire logic led_red_o,
	input wire logic led_green_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	// ----------------------------------------
	// properties
	// ----------------------------------------
	// a running machine with a free door is the hazard to rule out
	property p_run_locked; machine_en_o |-> !lock_solenoid_o; endproperty
	a_run_locked: assert property (p_run_locked) else $error("run with door free");
	property p_lock_first; $rose(machine_en_o) |-> $past(lock_solenoid_o, 3) == 1'b0; endproperty
	a_lock_first: assert property (p_lock_first) else $error("enable before lock");
	property p_stop_off; $rose(stop_btn_i) |-> ##[1:8] !machine_en_o; endproperty
	a_stop_off: assert property (p_stop_off) else $error("stop ignored");
	property p_hold_lock; $fell(machine_en_o) |-> !lock_solenoid_o [*8]; endproperty
	a_hold_lock: assert property (p_hold_lock) else $error("early unlock");
	property p_ack_closed; $rose(ack_req_o) |-> door_closed_i && !machine_en_o; endproperty
	a_ack_closed: assert property (p_ack_closed) else $error("bad ack request");
	property p_hw_trip; $rose(ext_volt_i) |-> ##[1:8] (led_red_o && !machine_en_o); endproperty
	a_hw_trip: assert property (p_hw_trip) else $error("hw fault not tripped");
	property p_led; led_green_o != led_red_o; endproperty
	a_led: assert property (p_led) else $error("indicators disagree");
	property p_ack_block; ack_req_o |-> !machine_en_o; endproperty
	a_ack_block: assert property (p_ack_block) else $error("run while ack pending");
endmodule

bind gdi_door_lock_supervisor gdi_checker u_gdi_checker (.clock_i, .rstn_i, .stop_btn_i,
	.door_closed_i, .ext_volt_i, .machine_en_o, .lock_solenoid_o, .ack_req_o, .led_red_o,
	.led_green_o);

// File: gdi_door_lock_supervisor_tb.sv
// self-checking bench: buttons, door and register port driven in sequence
// assumes short timing parameters: 4 cycles per ms, 3 ms unlock delay
`timescale 1ns/1ps
`include "gdi_defines.svh"

module gdi_door_lock_supervisor_tb;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] btn = 4'h0; // start, stop, ack, reset
	logic door = 1'b1;
	logic weld = 1'b0;
	logic ext_v = 1'b0;
	logic mod_miss = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [31:0] v;
	logic men, sol, ackr, red, green, irq, lfb, cfb;
	int fails = 0;
	int tests_run = 0;

	always #50 clock_i = ~clock_i;

	gdi_door_lock_supervisor #(.CYC_PER_MS(4), .UNLOCK_MS(3), .LOCK_TMO_MS(5), .FB_MS(3))
	u_gdi_door_lock_supervisor (.clock_i(clock_i), .rstn_i(rstn_i), .start_btn_i(btn[0]),
		.stop_btn_i(btn[1]), .ack_btn_i(btn[2]), .reset_btn_i(btn[3]), .door_closed_i(door),
		.lock_fb_i(lfb), .contactor_fb_i(cfb), .ext_volt_i(ext_v), .module_missing_i(mod_miss),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.machine_en_o(men), .lock_solenoid_o(sol), .ack_req_o(ackr), .led_red_o(red),
		.led_green_o(green), .irq_o(irq));

	gdi_plant_model u_gdi_plant_model (.clock_i(clock_i), .rstn_i(rstn_i), .machine_en_i(men),
		.lock_solenoid_i(sol), .door_closed_i(door), .weld_i(weld), .lock_fb_o(lfb),
		.contactor_fb_o(cfb));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// held long enough to pass the synchroniser and its agree stage
	task automatic press(input int i);
		@(posedge clock_i);
		btn[i] <= 1'b1;
		cyc(6);
		btn[i] <= 1'b0;
		cyc(4);
	endtask

	// state and error flags of a fault-free state
	task automatic st(input logic [7:0] e);
		rd_reg(`GDI_OFS_STATUS, v);
		chk("status", {21'h0, v[10:0]}, {24'h0, e});
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		cyc(8);
		rstn_i <= 1'b1;
		cyc(2);
		chk("en", men, 1'b0);
		chk("sol", sol, 1'b1);
		rd_reg(`GDI_OFS_DELAY, v);
		chk("delay", v, 32'h3);
		rd_reg(5'h14, v);
		chk("unmapped", v, 32'h0);
		press(0);
		chk("start in init", men, 1'b0);
		st(8'h01);
		door <= 1'b0;
		cyc(10);
		door <= 1'b1;
		cyc(10);
		chk("ack req", ackr, 1'b1);
		press(0);
		chk("start pending", men, 1'b0);
		press(2);
		chk("ack done", ackr, 1'b0);
		st(8'h08);
		chk("irq masked", irq, 1'b0);
		wr_reg(`GDI_OFS_IRQ_MASK, 32'hf);
		cyc(3);
		chk("irq", irq, 1'b1);
		rd_reg(`GDI_OFS_IRQ_STAT, v);
		chk("irq stat ack", v, 32'h2);
		wr_reg(`GDI_OFS_CTRL, 32'h0);
		press(0);
		chk("start disabled", men, 1'b0);
		wr_reg(`GDI_OFS_CTRL, 32'h1);
		press(0);
		cyc(10);
		chk("run", men, 1'b1);
		chk("locked", sol, 1'b0);
		wr_reg(`GDI_OFS_IRQ_STAT, 32'hf);
		cyc(3);
		chk("irq clear", irq, 1'b0);
		// longer delay so the restart press surely lands inside it
		wr_reg(`GDI_OFS_DELAY, 32'h6);
		press(1);
		chk("stopped", men, 1'b0);
		chk("held", sol, 1'b0);
		press(0);
		cyc(4);
		chk("restart in delay", men, 1'b1);
		press(1);
		cyc(30);
		chk("released", sol, 1'b1);
		st(8'h08);
		rd_reg(`GDI_OFS_IRQ_STAT, v);
		chk("irq stat run release", v, 32'hc);
		// stuck contactor while the machine is off
		weld <= 1'b1;
		cyc(30);
		rd_reg(`GDI_OFS_STATUS, v);
		chk("act err", v[9], 1'b1);
		chk("fault", v[7:0], 8'h80);
		chk("green", green, 1'b1);
		weld <= 1'b0;
		cyc(2);
		press(3);
		cyc(10);
		st(8'h08);
		// hardware faults re-latch while their cause stays
		for (int i = 0; i < 2; i++) begin
			ext_v <= (i == 0);
			mod_miss <= (i == 1);
			cyc(10);
			chk("red", red, 1'b1);
			press(3);
			chk("relatch", red, 1'b1);
			ext_v <= 1'b0;
			mod_miss <= 1'b0;
			cyc(4);
			press(3);
			cyc(10);
			chk("red off", red, 1'b0);
		end
		press(0);
		cyc(10);
		chk("run2", men, 1'b1);
		door <= 1'b0;
		cyc(10);
		chk("trip", men, 1'b0);
		rd_reg(`GDI_OFS_STATUS, v);
		chk("lock err", v[8], 1'b1);
		chk("green2", green, 1'b1);
		press(0);
		cyc(10);
		chk("no restart", men, 1'b0);
		door <= 1'b1;
		cyc(4);
		press(3);
		cyc(10);
		press(0);
		cyc(10);
		chk("recover", men, 1'b1);
		report_and_stop();
	end

	// run needs about 450 cycles; allow over twenty times that
	initial begin
		#1000000;
		fails++;
		report_and_stop();
	end
endmodule
